// ===== pkg/timer_event_counter_map.svh
// Register offsets, field positions, reset values and widths of the
// timer/event counter core.
// Assumes a 12-bit APB byte address with one aligned 32-bit word per register.
`ifndef TIMER_EVENT_COUNTER_MAP_SVH
`define TIMER_EVENT_COUNTER_MAP_SVH

// Byte offsets
`define TEC_OFF_CTL0 12'h000
`define TEC_OFF_CTL1 12'h004
`define TEC_OFF_IOC0 12'h008
`define TEC_OFF_IOC1 12'h00C
`define TEC_OFF_IOC2 12'h010
`define TEC_OFF_CCMODE 12'h014
`define TEC_OFF_CCR0 12'h020
`define TEC_OFF_CNT 12'h030

// Field positions
`define TEC_CTL0_RUN_BIT 7
`define TEC_CTL0_CKS_LSB 0
`define TEC_CTL1_EVT_BIT 5
`define TEC_CTL1_TRG_BIT 0
`define TEC_IOC2_EVT_LSB 0
`define TEC_IOC2_TRG_LSB 2

// Writable bit masks
`define TEC_CTL0_MASK 8'h87
`define TEC_CTL1_MASK 8'h21
`define TEC_IOC2_MASK 8'h0F

// Reset and idle values
`define TEC_RST_8 8'h00
`define TEC_RST_16 16'h0000
`define TEC_CNT_IDLE 16'hFFFF
`define TEC_CNT_READ_IDLE 16'h0000

// Prescaler width: division by up to 128
`define TEC_PRESC_W 7

`endif

// ===== pkg/timer_event_counter_pkg.sv
// Types shared by the timer/event counter core and its pin front end.
// Assumes the map header supplies all numeric constants.
package timer_event_counter_pkg;

   // Valid edge selection: bit 0 rising, bit 1 falling
   typedef logic [1:0] edge_sel_t;

   // Edge events seen on one synchronised pin
   typedef struct packed {
      logic rise;
      logic fall;
   } edge_s;

   // Layout of timer control register zero
   typedef struct packed {
      logic run_bit;
      logic [3:0] zero;
      logic [2:0] cks;
   } ctl0_s;

endpackage : timer_event_counter_pkg

// ===== verilog/timer_pin_sync.sv
// Two-stage synchroniser and edge finder for one timer input pin.
// Assumes the pin is asynchronous to clk_i; edges are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module timer_pin_sync (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic clear_i,
   input wire logic pin_i,
   output timer_event_counter_pkg::edge_s edge_o
);
   import timer_event_counter_pkg::*;

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // Synchroniser; first stage is read by the second only
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end

   // History follows the pin even when cleared, so no false edge on start
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sync_q;
      end
   end

   // Edge pulses, suppressed while the timer is stopped
   assign edge_o.rise = sync_q & ~prev_q & ~clear_i;
   assign edge_o.fall = ~sync_q & prev_q & ~clear_i;

endmodule : timer_pin_sync

`default_nettype wire

// ===== verilog/timer_event_counter_core.sv
// 16-bit timer/event counter core with four capture/compare channels,
// an APB register slave, a count-source selector and output control.
// Assumes pins are asynchronous and APB runs on clk_i.
// Operation
// RL1: Run bit low holds the counter at FFFFH.
// RL2: Counter read buffer returns count, or 0000H while stopped.
// RL3: Reset clears run bit, counter idles at all ones.
// RL4: Counter advances on internal clock ticks or external event edges.
// RL5: Compare writes to a channel load its hidden compare buffer.
// RL6: Count equal to a compare buffer raises that channel's request.
// RL7: Compare buffers are unreachable by software except via their registers.
// RL8: Reset clears every capture/compare register and buffer to 0000H.
// RL9: Four channels, four inputs, event input, trigger input, four requests.
// RL10: Edge select picks none, rising, falling or both edges.
// RL11: Output control register steers the four timer outputs.
// RL12: Count source is one of eight internal clocks or event.
// RL13: Divider code n selects clock divided by two to the n.
// RL14: Control zero is 8 bits, reset 00H, run bit 7, divider 2:0.
// RL15: Control registers accept byte writes; bit access via read-modify-write.
// RL16: Rewriting control zero with its value leaves timing undisturbed.
// RL17: Timer input 0 serves as capture, event or trigger input.
// RL18: Clearing run resets internal state; setting run counts from idle.
// RL19: Software changes divider only while stopped or when setting run.
`timescale 1ns/1ps
`default_nettype none
`include "timer_event_counter_map.svh"

module timer_event_counter_core #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // Timer pins and requests
   input wire logic [NUM_CH-1:0] timer_input_i,
   output logic [NUM_CH-1:0] timer_output_o,
   output logic [NUM_CH-1:0] compare_match_irq_o
);
   import timer_event_counter_pkg::*;

   // Elaboration check: the address map holds at most four channels
   if (NUM_CH < 1 || NUM_CH > 4) begin : g_bad_num_ch
      $error("NUM_CH must lie between 1 and 4");
   end

   // Register state
   ctl0_s timer_control_zero_q;
   logic [7:0] timer_control_one_q;
   logic [7:0] output_control_reg_q;
   logic [7:0] edge_select_reg_a_q;
   logic [7:0] edge_select_reg_b_q;
   logic [7:0] ccmode_q;
   logic [15:0] ccr_q [NUM_CH];
   logic [15:0] cmp_buf_q [NUM_CH];

   // Timer state
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic [`TEC_PRESC_W-1:0] presc_q;
   logic [NUM_CH-1:0] irq_q;
   logic [NUM_CH-1:0] toggle_q;
   logic [NUM_CH-1:0] out_q;

   // APB answer registers
   logic [31:0] prdata_q;
   logic pslverr_q;

   // Decoded controls
   logic run;
   logic evt_mode;
   logic trg_en;
   logic tick;
   logic count_en;
   logic trigger;
   logic [NUM_CH-1:0] cap_edge;
   logic [NUM_CH-1:0] ccr_wr;
   edge_s pin_edge [NUM_CH];

   logic setup_ph;
   logic wr_acc;

   // Valid edge decode, used for capture, event and trigger paths
   function automatic logic edge_ok(input edge_sel_t sel, input edge_s e);
      return (sel[0] & e.rise) | (sel[1] & e.fall);
   endfunction : edge_ok

   // Internal tick: all low n prescaler bits set gives division by 2^n
   function automatic logic div_tick(input logic [2:0] cks,
                                     input logic [`TEC_PRESC_W-1:0] presc);
      logic [7:0] m;
      m = (8'h01 << cks) - 8'h01;
      return (presc & m[`TEC_PRESC_W-1:0]) == m[`TEC_PRESC_W-1:0];
   endfunction : div_tick

   // Byte-lane merge of an 8-bit register under a writable mask
   function automatic logic [7:0] wr8(input logic [7:0] old,
                                      input logic [7:0] mask);
      return pstrb_i[0] ? (pwdata_i[7:0] & mask) : old;
   endfunction : wr8

   // Word decode of one offset
   function automatic logic hit(input logic [11:0] off);
      return paddr_i[11:2] == off[11:2];
   endfunction : hit

   // Bus phases
   assign setup_ph = psel_i & ~penable_i;
   assign wr_acc = psel_i & penable_i & pwrite_i;

   // Control field decode
   assign run = timer_control_zero_q.run_bit;
   assign evt_mode = timer_control_one_q[`TEC_CTL1_EVT_BIT];
   assign trg_en = timer_control_one_q[`TEC_CTL1_TRG_BIT];

   // Pin front ends, one per timer input
   // Own synchroniser per input, so every edge arrives with the same latency
   genvar gi;
   for (gi = 0; gi < NUM_CH; gi++) begin : g_pin
      // RL18 edge state cleared
      timer_pin_sync u_sync (
         .clk_i(clk_i),
         .sys_rst_i(sys_rst_i),
         .clear_i(~run),
         .pin_i(timer_input_i[gi]),
         .edge_o(pin_edge[gi])
      );
      // RL10 capture edge select
      assign cap_edge[gi] = edge_ok(edge_select_reg_a_q[2*gi +: 2], pin_edge[gi]);
      // Bus pins compared here directly, so a change of address is never missed
      assign ccr_wr[gi] = wr_acc &
                          (paddr_i[11:2] == 10'((`TEC_OFF_CCR0 + 4 * gi) >> 2));
   end

   // RL17 input 0 as trigger
   assign trigger = trg_en &
                    edge_ok(edge_select_reg_b_q[`TEC_IOC2_TRG_LSB +: 2], pin_edge[0]);

   // RL12 count source select
   // RL13 divided clock tick
   assign tick = div_tick(timer_control_zero_q.cks, presc_q);
   // RL4 event or internal clock
   assign count_en = run & (evt_mode ?
      edge_ok(edge_select_reg_b_q[`TEC_IOC2_EVT_LSB +: 2], pin_edge[0]) : tick);

   // Reserved bits are masked on write, so they always read as zero
   // RL14 control zero register
   // RL15 byte lane write
   // RL16 same value is harmless
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         // RL3 run bit cleared
         timer_control_zero_q <= ctl0_s'(`TEC_RST_8);
      end else if (wr_acc && hit(`TEC_OFF_CTL0)) begin
         timer_control_zero_q <= ctl0_s'(wr8(timer_control_zero_q, `TEC_CTL0_MASK));
      end
   end

   // Remaining 8-bit control registers
   // Offsets not decoded here leave every register untouched
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         timer_control_one_q <= `TEC_RST_8;
         output_control_reg_q <= `TEC_RST_8;
         edge_select_reg_a_q <= `TEC_RST_8;
         edge_select_reg_b_q <= `TEC_RST_8;
         ccmode_q <= `TEC_RST_8;
      end else if (wr_acc) begin
         if (hit(`TEC_OFF_CTL1)) begin
            timer_control_one_q <= wr8(timer_control_one_q, `TEC_CTL1_MASK);
         end
         if (hit(`TEC_OFF_IOC0)) begin
            output_control_reg_q <= wr8(output_control_reg_q, 8'hFF);
         end
         if (hit(`TEC_OFF_IOC1)) begin
            edge_select_reg_a_q <= wr8(edge_select_reg_a_q, 8'hFF);
         end
         if (hit(`TEC_OFF_IOC2)) begin
            edge_select_reg_b_q <= wr8(edge_select_reg_b_q, `TEC_IOC2_MASK);
         end
         if (hit(`TEC_OFF_CCMODE)) begin
            ccmode_q <= wr8(ccmode_q, 8'hFF);
         end
      end
   end

   // One shared prescaler serves all eight rates; a code change while
   // running takes effect at the next tick decode
   // RL18 prescaler reset while stopped
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         presc_q <= '0;
      end else if (!run) begin
         presc_q <= '0;
      end else begin
         presc_q <= presc_q + `TEC_PRESC_W'(1);
      end
   end

   // Counter next value; trigger restarts from idle
   // Trigger is given priority over a count step in the same cycle
   always_comb begin
      cnt_d = cnt_q;
      if (!run) begin
         // RL1 idle at all ones
         cnt_d = `TEC_CNT_IDLE;
      end else if (trigger) begin
         cnt_d = `TEC_CNT_IDLE;
      end else if (count_en) begin
         // RL18 first count leaves idle
         cnt_d = cnt_q + 16'h0001;
      end
   end

   // RL1 16-bit up-counter
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q <= `TEC_CNT_IDLE;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Per-channel capture/compare registers, buffers and outputs
   for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      logic [15:0] ccr_wval;
      logic match;

      assign ccr_wval = {pstrb_i[1] ? pwdata_i[15:8] : ccr_q[gi][15:8],
                         pstrb_i[0] ? pwdata_i[7:0] : ccr_q[gi][7:0]};
      // Match only on a real count step, so a stopped timer stays quiet
      assign match = count_en & ~trigger & ~ccmode_q[gi] &
                     (cnt_d == cmp_buf_q[gi]);

      // Capture wins over a software write in the same cycle
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            // RL8 register cleared
            ccr_q[gi] <= `TEC_RST_16;
         end else if (ccmode_q[gi] && run && cap_edge[gi]) begin
            ccr_q[gi] <= cnt_q;
         end else if (ccr_wr[gi]) begin
            ccr_q[gi] <= ccr_wval;
         end
      end

      // RL5 write loads buffer
      // RL7 buffer reached only here
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            // RL8 buffer cleared
            cmp_buf_q[gi] <= `TEC_RST_16;
         end else if (ccr_wr[gi] && !ccmode_q[gi]) begin
            cmp_buf_q[gi] <= ccr_wval;
         end
      end

      // RL6 match request pulse
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            irq_q[gi] <= 1'b0;
         end else begin
            irq_q[gi] <= match;
         end
      end

      // Output toggles on each match; toggle state restarts low while stopped
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            toggle_q[gi] <= 1'b0;
         end else if (!run) begin
            toggle_q[gi] <= 1'b0;
         end else if (match) begin
            toggle_q[gi] <= ~toggle_q[gi];
         end
      end

      // RL11 output enable and level
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            out_q[gi] <= 1'b0;
         end else begin
            out_q[gi] <= output_control_reg_q[2*gi] &
                         (toggle_q[gi] ^ output_control_reg_q[2*gi+1]);
         end
      end
   end

   // Read data and error are latched in the setup phase
   // Latching early keeps prdata steady through the whole access phase
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         prdata_q <= 32'h0000_0000;
         pslverr_q <= 1'b0;
         if (hit(`TEC_OFF_CTL0)) begin
            prdata_q <= {24'h00_0000, timer_control_zero_q};
         end else if (hit(`TEC_OFF_CTL1)) begin
            prdata_q <= {24'h00_0000, timer_control_one_q};
         end else if (hit(`TEC_OFF_IOC0)) begin
            prdata_q <= {24'h00_0000, output_control_reg_q};
         end else if (hit(`TEC_OFF_IOC1)) begin
            prdata_q <= {24'h00_0000, edge_select_reg_a_q};
         end else if (hit(`TEC_OFF_IOC2)) begin
            prdata_q <= {24'h00_0000, edge_select_reg_b_q};
         end else if (hit(`TEC_OFF_CCMODE)) begin
            prdata_q <= {24'h00_0000, ccmode_q};
         end else if (hit(`TEC_OFF_CNT)) begin
            // RL2 counter read buffer
            prdata_q <= {16'h0000, run ? cnt_q : `TEC_CNT_READ_IDLE};
         end else begin
            pslverr_q <= 1'b1;
            for (int i = 0; i < NUM_CH; i++) begin
               if (hit(`TEC_OFF_CCR0 + 12'(4 * i))) begin
                  prdata_q <= {16'h0000, ccr_q[i]};
                  pslverr_q <= 1'b0;
               end
            end
         end
      end
   end

   // RL9 four channels exposed
   assign timer_output_o = out_q;
   assign compare_match_irq_o = irq_q;

   // Zero wait states: access phase always completes at once
   // Every register answers from flops, so no wait state is ever needed
   assign pready_o = 1'b1;
   assign prdata_o = prdata_q;
   assign pslverr_o = pslverr_q & psel_i & penable_i;

endmodule : timer_event_counter_core

`default_nettype wire

// ===== dv/timer_event_counter_core_sva.sv
// Port checker for the timer/event counter core.
// Assumes APB runs on clk_i and the map header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "timer_event_counter_map.svh"

module timer_event_counter_core_chk #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [NUM_CH-1:0] timer_input_i,
   input wire logic [NUM_CH-1:0] timer_output_o,
   input wire logic [NUM_CH-1:0] compare_match_irq_o
);
   logic [7:0] ctl0_q;
   wire logic [9:0] word = paddr_i[11:2];
   wire logic mapped = word <= 10'h5 || (word >= 10'h8 && word <= 10'hC);
   wire logic acc = psel_i && penable_i;

   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   // Shadow of control zero, only the writable bits
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctl0_q <= 8'h00;
      end else if (acc && pwrite_i && word == 10'h0 && pstrb_i[0]) begin
         ctl0_q <= pwdata_i[7:0] & `TEC_CTL0_MASK;
      end
   end

   sequence rd_s(logic [9:0] a);
      acc && !pwrite_i && word == a;
   endsequence
   sequence setup_then_access_s;
      psel_i && !penable_i ##1 acc;
   endsequence

   chk_ctl0_read: assert property (rd_s(10'h0) |-> prdata_o == {24'h0, ctl0_q})
      else $error("control zero read differs from written value");
   chk_cnt_stopped: assert property (rd_s(10'hC) ##0 !ctl0_q[7] |-> prdata_o == 32'h0)
      else $error("counter read not zero while stopped");
   chk_err_decode: assert property (pslverr_o == (acc && !mapped))
      else $error("error response does not follow address decode");
   chk_unmapped_zero: assert property (acc && !pwrite_i && !mapped |-> prdata_o == 32'h0)
      else $error("unmapped read returned data");
   chk_ccr_width: assert property (acc && !pwrite_i && paddr_i[11:4] == 8'h02
      |-> prdata_o[31:16] == 16'h0)
      else $error("channel register wider than 16 bits");
   chk_irq_single: assert property ((compare_match_irq_o & $past(compare_match_irq_o)) == '0)
      else $error("match request longer than one cycle");
   chk_irq_stopped: assert property (!ctl0_q[7] && !$past(ctl0_q[7]) && !$past(ctl0_q[7], 2)
      |-> compare_match_irq_o == '0)
      else $error("match request while stopped");
   chk_zero_wait: assert property (setup_then_access_s |-> pready_o)
      else $error("access phase not answered at once");
endmodule : timer_event_counter_core_chk

bind timer_event_counter_core timer_event_counter_core_chk #(.NUM_CH(NUM_CH)) u_chk (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
   .timer_input_i(timer_input_i), .timer_output_o(timer_output_o),
   .compare_match_irq_o(compare_match_irq_o));
`default_nettype wire

// ===== dv/timer_pin_model.sv
// Behavioural source for the timer input pins.
// Assumes the bench asks for one level flip per request bit.
`timescale 1ns/1ps
`default_nettype none

module timer_pin_model #(
   parameter int NUM_CH = 4
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [NUM_CH-1:0] toggle_i,
   output logic [NUM_CH-1:0] pin_o
);
   // Levels are held between flips, as a slow external source would
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pin_o <= '0;
      end else begin
         pin_o <= pin_o ^ toggle_i;
      end
   end
endmodule : timer_pin_model
`default_nettype wire

// ===== dv/timer_event_counter_core_test.sv
// Self-checking bench for the timer/event counter core.
// Assumes the checker is bound in and the pin model drives the inputs.
`timescale 1ns/1ps
`default_nettype none

module timer_event_counter_core_test;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [11:0] paddr_i = '0;
   logic [31:0] pwdata_i = '0, prdata_o, lfsr = 32'h564D;
   logic [3:0] pstrb_i = '0, toggle = '0, pins, outs, irq;
   logic pready_o, pslverr_o, run_seen = 1'b0;
   logic [32:0] rd_q[$];
   logic [15:0] irq_q[$];
   logic [11:0] rst_addr[6] = '{12'h000, 12'h020, 12'h024, 12'h028, 12'h02C, 12'h030};
   int failures = 0, checks_done = 0, cyc = 0, ticks = 0;

   always #4 clk_i = ~clk_i;

   timer_event_counter_core #(.NUM_CH(4)) dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
      .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
      .pslverr_o(pslverr_o), .timer_input_i(pins), .timer_output_o(outs),
      .compare_match_irq_o(irq));
   timer_pin_model #(.NUM_CH(4)) pm (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .toggle_i(toggle), .pin_o(pins));

   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : next_rand

   task automatic check_val(input string what, input logic [32:0] exp, input logic [32:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check_val

   task automatic results();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : results

   // One APB transfer; read expectations go to the queue before the access
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [32:0] e);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      pstrb_i <= s;
      if (!w) rd_q.push_back(e);
      @(posedge clk_i);
      penable_i <= 1'b1;
      do @(posedge clk_i); while (pready_o !== 1'b1);
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hF, '0);
   endtask : wr

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, '0, 4'h0, e);
   endtask : rd

   // One level flip on the selected pins, then time for the synchroniser
   task automatic pulse(input logic [3:0] t);
      toggle <= t;
      @(posedge clk_i);
      toggle <= 4'h0;
      repeat (5) @(posedge clk_i);
   endtask : pulse

   // Watcher: read data, match requests with cycles since start, timeout
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      ticks <= ticks + 1;
      if (psel_i && penable_i && pwrite_i && paddr_i == 12'h000) begin
         run_seen <= pwdata_i[7];
         if (pwdata_i[7] && !run_seen) cyc <= 0;
      end
      if (psel_i && penable_i && pready_o && !pwrite_i)
         check_val("read data", rd_q.pop_front(), {pslverr_o, prdata_o});
      if (irq !== 4'h0) check_val("match", irq_q.pop_front(), {irq, cyc[11:0]});
      if (ticks == 20000) begin
         failures++;
         results();
      end
   end

   initial begin
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      foreach (rst_addr[i]) rd(rst_addr[i], 33'h0);
      $display("test reset values done");
      wr(12'h000, 32'h7F);
      rd(12'h000, 33'h07);
      apb(1'b1, 12'h000, 32'h0, 4'h0, '0);
      rd(12'h000, 33'h07);
      wr(12'h000, 32'h0);
      wr(12'h030, 32'h1234);
      rd(12'h030, 33'h0);
      rd(12'h040, {1'b1, 32'h0});
      for (int i = 0; i < 4; i++) begin
         lfsr = next_rand(lfsr);
         wr(12'h020 + 12'(4 * i), lfsr);
         rd(12'h020 + 12'(4 * i), {17'h0, lfsr[15:0]});
      end
      $display("test registers done");
      wr(12'h008, 32'h55);
      for (int n = 0; n < 8; n++) begin
         for (int c = 0; c < 4; c++) wr(12'h020 + 12'(4 * c), (c == n % 4) ? n + 1 : 32'hFFFE);
         irq_q.push_back({4'(1 << (n % 4)), 12'((n + 2) << n)});
         // divider given in the same write that starts the count
         wr(12'h000, 32'h80 | n);
         wr(12'h000, 32'h80 | n);
         repeat (((n + 2) << n) + 8) @(posedge clk_i);
         check_val("outputs", 33'(1 << (n % 4)), 33'(outs));
         wr(12'h000, 32'h0);
         check_val("pending matches", 33'h0, 33'(irq_q.size()));
      end
      wr(12'h008, 32'hFF);
      @(posedge clk_i);
      check_val("inverted outputs", 33'hF, 33'(outs));
      $display("test internal clock done");
      wr(12'h004, 32'h20);
      for (int e = 0; e < 4; e++) begin
         wr(12'h010, e);
         wr(12'h000, 32'h80);
         repeat (8) pulse(4'h1);
         rd(12'h030, {17'h0, 16'((e[0] + e[1]) * 4 - 1)});
         wr(12'h000, 32'h0);
      end
      $display("test event count done");
      // Input 0 counts both edges; a rising edge on input 1 captures into channel 1
      wr(12'h014, 32'h2);
      wr(12'h00C, 32'h4);
      wr(12'h000, 32'h80);
      repeat (3) pulse(4'h1);
      pulse(4'h2);
      rd(12'h024, 33'h2);
      wr(12'h000, 32'h0);
      // Rising edges count, falling edges of the same input restart from idle
      wr(12'h004, 32'h21);
      wr(12'h010, 32'h9);
      wr(12'h000, 32'h80);
      repeat (3) pulse(4'h1);
      rd(12'h030, 33'hFFFF);
      wr(12'h000, 32'h0);
      $display("test capture and trigger done");
      results();
   end
endmodule : timer_event_counter_core_test
`default_nettype wire
